// ### design/gtol_core.sv
// genlock reference selection, lock action and timing offset control
`timescale 1ns/1ns
`default_nettype none
module gtol_core #(
    parameter int VW = 12,
    parameter int CW = 13,
    parameter int FW = 8
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire gtol_pkg::gtol_fmt_t format_in,
    input wire logic manual_mode_in,
    input wire logic lock_now_in,
    input wire logic ref_usable_in,
    input wire gtol_pkg::gtol_detect_t detect_in,
    input wire gtol_pkg::gtol_offset_t offset_req_in,
    output gtol_pkg::gtol_offset_t offset_out,
    output logic offset_enable_out,
    output gtol_pkg::gtol_cclk_t coarse_clk_out,
    output gtol_pkg::gtol_hd_t hd_format_out,
    output logic [11:0] expected_lines_out,
    output logic locked_out,
    output logic waiting_manual_out,
    output logic external_reference_indicator_out,
    output logic offset_clamped_out
);
    // elaboration-time refusal of any widths other than those of the packed offset struct
    if (VW != 12 || CW != 13 || FW != 8) begin : g_width_check
        $error("gtol_core: field widths must match the package offset struct");
    end

    typedef struct packed {
        gtol_pkg::gtol_state_t st;
        gtol_pkg::gtol_offset_t off;
        logic off_en;
        gtol_pkg::gtol_cclk_t cclk;
        gtol_pkg::gtol_hd_t hd;
        logic [11:0] lines;
        logic clamped;
    } gtol_core_state_t;

    gtol_core_state_t r;
    gtol_core_state_t next_r;

    logic [11:0] vlim;
    logic [12:0] clim;
    logic [7:0] flim;
    gtol_pkg::gtol_hd_t hd_det;

    // tri-level variant classification from measured lines, scan and rate
    always_comb begin
        hd_det = gtol_pkg::GTOL_HD_NONE;
        if (detect_in.lines == gtol_pkg::HD720_LINES) begin
            unique case (detect_in.rate)
                2'd1: hd_det = gtol_pkg::GTOL_HD_720_50P;
                2'd0: hd_det = detect_in.fractional ? gtol_pkg::GTOL_HD_720_5994P
                                                    : gtol_pkg::GTOL_HD_720_60P;
                default: hd_det = gtol_pkg::GTOL_HD_NONE;
            endcase
        end else if (detect_in.lines == gtol_pkg::HD1080_LINES) begin
            if (detect_in.interlaced) begin
                unique case (detect_in.rate)
                    2'd1: hd_det = gtol_pkg::GTOL_HD_1080_50I;
                    2'd0: hd_det = detect_in.fractional ? gtol_pkg::GTOL_HD_1080_5994I
                                                        : gtol_pkg::GTOL_HD_1080_60I;
                    default: hd_det = gtol_pkg::GTOL_HD_NONE;
                endcase
            end else if (detect_in.segmented) begin
                if (detect_in.rate == 2'd2) begin
                    hd_det = detect_in.fractional ? gtol_pkg::GTOL_HD_1080_2398SF
                                                  : gtol_pkg::GTOL_HD_1080_24SF;
                end
            end else if (detect_in.progressive) begin
                unique case (detect_in.rate)
                    2'd1: hd_det = gtol_pkg::GTOL_HD_1080_25P;
                    2'd0: hd_det = detect_in.fractional ? gtol_pkg::GTOL_HD_1080_2997P
                                                        : gtol_pkg::GTOL_HD_1080_30P;
                    2'd2: hd_det = detect_in.fractional ? gtol_pkg::GTOL_HD_1080_2398P
                                                        : gtol_pkg::GTOL_HD_1080_24P;
                    default: hd_det = gtol_pkg::GTOL_HD_NONE;
                endcase
            end
        end
    end

    // per-format vertical, coarse and fine offset limits
    always_comb begin
        vlim = gtol_pkg::VLIM_CW;
        clim = gtol_pkg::CLIM_CW;
        flim = 8'h00;
        unique case (format_in)
            gtol_pkg::GTOL_FMT_NTSC: begin
                vlim = gtol_pkg::VLIM_NTSC;
                clim = gtol_pkg::CLIM_NTSC;
                flim = gtol_pkg::FLIM_SD;
            end
            gtol_pkg::GTOL_FMT_PAL: begin
                vlim = gtol_pkg::VLIM_PAL;
                clim = gtol_pkg::CLIM_PAL;
                flim = gtol_pkg::FLIM_SD;
            end
            gtol_pkg::GTOL_FMT_TRI: begin
                flim = gtol_pkg::FLIM_HD;
                if (detect_in.lines == gtol_pkg::HD720_LINES) begin
                    vlim = gtol_pkg::VLIM_720;
                    clim = (detect_in.rate == 2'd1) ? gtol_pkg::CLIM_720_50
                                                    : gtol_pkg::CLIM_720_60;
                end else begin
                    vlim = gtol_pkg::VLIM_1080;
                    clim = (detect_in.rate == 2'd1) ? gtol_pkg::CLIM_1080_50 :
                           (detect_in.rate == 2'd2) ? gtol_pkg::CLIM_1080_24
                                                    : gtol_pkg::CLIM_1080_60;
                end
            end
            default: begin
                vlim = gtol_pkg::VLIM_CW;
                clim = gtol_pkg::CLIM_CW;
                flim = 8'h00; // no fine term for cw or pps
            end
        endcase
    end

    // lock state, clamping and selection update
    always_comb begin
        next_r = r;
        next_r.clamped = 1'b0;
        // expected line count for the selected format, measured lines for tri-level
        unique case (format_in)
            gtol_pkg::GTOL_FMT_NTSC: next_r.lines = gtol_pkg::NTSC_LINES;
            gtol_pkg::GTOL_FMT_PAL: next_r.lines = gtol_pkg::PAL_LINES;
            gtol_pkg::GTOL_FMT_TRI: next_r.lines = detect_in.lines;
            default: next_r.lines = 12'h000; // cw has no lines
        endcase
        next_r.hd = (format_in == gtol_pkg::GTOL_FMT_TRI) ? hd_det : gtol_pkg::GTOL_HD_NONE;
        // coarse step clock per format
        unique case (format_in)
            gtol_pkg::GTOL_FMT_NTSC, gtol_pkg::GTOL_FMT_PAL:
                next_r.cclk = gtol_pkg::GTOL_CLK_54M;
            gtol_pkg::GTOL_FMT_TRI:
                next_r.cclk = detect_in.fractional ? gtol_pkg::GTOL_CLK_74M18
                                                   : gtol_pkg::GTOL_CLK_74M25;
            default: next_r.cclk = gtol_pkg::GTOL_CLK_NONE;
        endcase

        // offsets clamp to the format range, never wrap
        next_r.off_en = (format_in != gtol_pkg::GTOL_FMT_PPS);
        if (next_r.off_en) begin
            next_r.off = offset_req_in;
            if (offset_req_in.vert > $signed({1'b0, vlim[10:0]})) begin
                next_r.off.vert = $signed({1'b0, vlim[10:0]});
                next_r.clamped = 1'b1;
            end else if (offset_req_in.vert < -$signed({1'b0, vlim[10:0]})) begin
                next_r.off.vert = -$signed({1'b0, vlim[10:0]});
                next_r.clamped = 1'b1;
            end
            if (offset_req_in.coarse > $signed({1'b0, clim[11:0]})) begin
                next_r.off.coarse = $signed({1'b0, clim[11:0]});
                next_r.clamped = 1'b1;
            end else if (offset_req_in.coarse < -$signed({1'b0, clim[11:0]})) begin
                next_r.off.coarse = -$signed({1'b0, clim[11:0]});
                next_r.clamped = 1'b1;
            end
            if (offset_req_in.fine > $signed({1'b0, flim[6:0]})) begin
                next_r.off.fine = $signed({1'b0, flim[6:0]});
                next_r.clamped = 1'b1;
            end else if (offset_req_in.fine < -$signed({1'b0, flim[6:0]})) begin
                next_r.off.fine = -$signed({1'b0, flim[6:0]});
                next_r.clamped = 1'b1;
            end
        end else begin
            next_r.off = '0;
        end

        // lock action
        unique case (r.st)
            gtol_pkg::GTOL_ST_UNLOCKED: begin
                if (ref_usable_in) begin
                    next_r.st = gtol_pkg::GTOL_ST_LOCKED;
                end
            end
            gtol_pkg::GTOL_ST_LOCKED: begin
                if (!ref_usable_in) begin
                    next_r.st = manual_mode_in ? gtol_pkg::GTOL_ST_WAIT_MANUAL
                                               : gtol_pkg::GTOL_ST_UNLOCKED;
                end
            end
            gtol_pkg::GTOL_ST_WAIT_MANUAL: begin
                if (ref_usable_in && (lock_now_in || !manual_mode_in)) begin
                    next_r.st = gtol_pkg::GTOL_ST_LOCKED;
                end
            end
            default: next_r.st = gtol_pkg::GTOL_ST_UNLOCKED;
        endcase
    end

    // state register
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign offset_out = r.off;
    assign offset_enable_out = r.off_en;
    assign coarse_clk_out = r.cclk;
    assign hd_format_out = r.hd;
    assign expected_lines_out = r.lines;
    assign locked_out = (r.st == gtol_pkg::GTOL_ST_LOCKED);
    assign waiting_manual_out = (r.st == gtol_pkg::GTOL_ST_WAIT_MANUAL);
    assign external_reference_indicator_out = (r.st != gtol_pkg::GTOL_ST_LOCKED); // red
    assign offset_clamped_out = r.clamped;
endmodule
`default_nettype wire

// ### design/gtol_pkg.sv
// package for the genlock timing offset and lock control block
package gtol_pkg;

    // reference formats selectable by software
    typedef enum logic [2:0] {
        GTOL_FMT_NTSC,
        GTOL_FMT_PAL,
        GTOL_FMT_TRI,
        GTOL_FMT_CW,
        GTOL_FMT_PPS
    } gtol_fmt_t;

    // tri-level variants reported by detection
    typedef enum logic [3:0] {
        GTOL_HD_NONE,
        GTOL_HD_1080_60I,
        GTOL_HD_1080_5994I,
        GTOL_HD_1080_50I,
        GTOL_HD_1080_30P,
        GTOL_HD_1080_2997P,
        GTOL_HD_1080_25P,
        GTOL_HD_1080_24P,
        GTOL_HD_1080_2398P,
        GTOL_HD_1080_24SF,
        GTOL_HD_1080_2398SF,
        GTOL_HD_720_60P,
        GTOL_HD_720_5994P,
        GTOL_HD_720_50P
    } gtol_hd_t;

    // coarse step clock chosen per format
    typedef enum logic [1:0] {
        GTOL_CLK_54M,
        GTOL_CLK_74M25,
        GTOL_CLK_74M18,
        GTOL_CLK_NONE
    } gtol_cclk_t;

    typedef enum logic [1:0] {
        GTOL_ST_UNLOCKED,
        GTOL_ST_LOCKED,
        GTOL_ST_WAIT_MANUAL
    } gtol_state_t;

    // expected reference figures
    localparam logic [11:0] NTSC_LINES = 12'd525;
    localparam logic [11:0] PAL_LINES = 12'd625;
    localparam logic [11:0] HD1080_LINES = 12'd1125;
    localparam logic [11:0] HD720_LINES = 12'd750;
    localparam int NTSC_FIELD_MHZ = 59940; // field rate in millihertz
    localparam int PAL_FIELD_MHZ = 50000;
    localparam int CW_FREQ_HZ = 10000000;

    // offset limits; fine in 0.1 ns units
    localparam logic [11:0] VLIM_NTSC = 12'd525;
    localparam logic [11:0] VLIM_PAL = 12'd1250;
    localparam logic [11:0] VLIM_1080 = 12'd562;
    localparam logic [11:0] VLIM_720 = 12'd375;
    localparam logic [11:0] VLIM_CW = 12'd1125;
    localparam logic [7:0] FLIM_SD = 8'd100;
    localparam logic [7:0] FLIM_HD = 8'd70;
    // coarse limits in clock periods (usec times clock rate, rounded down)
    localparam logic [12:0] CLIM_NTSC = 13'd3432;
    localparam logic [12:0] CLIM_PAL = 13'd3456;
    localparam logic [12:0] CLIM_1080_60 = 13'd2200;
    localparam logic [12:0] CLIM_1080_50 = 13'd2640;
    localparam logic [12:0] CLIM_1080_24 = 13'd2750;
    localparam logic [12:0] CLIM_720_60 = 13'd1650;
    localparam logic [12:0] CLIM_720_50 = 13'd1980;
    localparam logic [12:0] CLIM_CW = 13'd3456;

    // settings carried together
    typedef struct packed {
        logic signed [11:0] vert;
        logic signed [12:0] coarse;
        logic signed [7:0] fine;
    } gtol_offset_t;

    // detection result from the reference front end
    typedef struct packed {
        logic [11:0] lines;
        logic interlaced;
        logic segmented;
        logic fractional;
        logic [1:0] rate; // 0: 60/30, 1: 50/25, 2: 24
        logic progressive;
    } gtol_detect_t;
endpackage

// ### test/gtol_core_monitor.sv
// assertion checker for the genlock offset and lock control block
`timescale 1ns/1ns
`default_nettype none
module gtol_core_monitor (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire gtol_pkg::gtol_fmt_t format_in,
    input wire logic manual_mode_in,
    input wire logic lock_now_in,
    input wire logic ref_usable_in,
    input wire gtol_pkg::gtol_offset_t offset_req_in,
    input wire gtol_pkg::gtol_offset_t offset_out,
    input wire logic offset_enable_out,
    input wire gtol_pkg::gtol_cclk_t coarse_clk_out,
    input wire logic [11:0] expected_lines_out,
    input wire logic locked_out,
    input wire logic waiting_manual_out,
    input wire logic external_reference_indicator_out,
    input wire logic offset_clamped_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // lock lost in manual mode, then parked awaiting a command
    sequence s_lost;
        locked_out && manual_mode_in && !ref_usable_in;
    endsequence
    sequence s_parked;
        waiting_manual_out && manual_mode_in && !lock_now_in;
    endsequence
    a_ntsc_lines: assert property (format_in == gtol_pkg::GTOL_FMT_NTSC |=>
        expected_lines_out == 12'h20D) else $error("ntsc line count wrong");
    a_pal_lines: assert property (format_in == gtol_pkg::GTOL_FMT_PAL |=>
        expected_lines_out == 12'h271) else $error("pal line count wrong");
    a_sd_step: assert property (format_in inside {gtol_pkg::GTOL_FMT_NTSC,
        gtol_pkg::GTOL_FMT_PAL} |=> coarse_clk_out == gtol_pkg::GTOL_CLK_54M)
        else $error("sd coarse clock wrong");
    a_pps_no_offset: assert property (format_in == gtol_pkg::GTOL_FMT_PPS |=>
        !offset_enable_out && offset_out == 33'h0) else $error("offset live with pps");
    a_auto_relock: assert property (!manual_mode_in && ref_usable_in |=> locked_out)
        else $error("auto mode did not relock");
    a_manual_wait: assert property (s_lost |=> waiting_manual_out
        && external_reference_indicator_out) else $error("manual loss not parked");
    a_manual_hold: assert property (s_parked |=> !locked_out)
        else $error("relocked without command");
    a_lock_now: assert property (waiting_manual_out && lock_now_in && ref_usable_in
        |=> locked_out) else $error("lock now ignored");
    a_fine_clamp: assert property (format_in == gtol_pkg::GTOL_FMT_NTSC
        && $signed(offset_req_in.fine) > 8'sh64 |=> offset_out.fine == 8'h64
        && offset_clamped_out) else $error("fine not clamped");
    a_vert_edge: assert property (format_in == gtol_pkg::GTOL_FMT_PAL
        && offset_req_in.vert == 12'h4E2 |=> offset_out.vert == 12'h4E2)
        else $error("vertical limit value altered");
endmodule
bind gtol_core gtol_core_monitor mon (.core_clk_in, .rst_in, .format_in, .manual_mode_in,
    .lock_now_in, .ref_usable_in, .offset_req_in, .offset_out, .offset_enable_out,
    .coarse_clk_out, .expected_lines_out, .locked_out, .waiting_manual_out,
    .external_reference_indicator_out, .offset_clamped_out);
`default_nettype wire

// ### test/gtol_ref_source.sv
// model of the external reference source feeding the genlock block
`timescale 1ns/1ns
`default_nettype none
module gtol_ref_source (
    input wire logic clk_in,
    input wire logic present_in,
    input wire logic [1:0] kind_in,
    output logic usable_out,
    output var gtol_pkg::gtol_detect_t detect_out
);
    gtol_pkg::gtol_detect_t v;
    // tri-level variant sent: 0 1080 59.94i, 1 720 50p, 2 1080 23.98sf, 3 1080 25p
    always_comb begin
        v = '0;
        v.lines = (kind_in == 2'h1) ? 12'h2EE : 12'h465;
        v.interlaced = (kind_in == 2'h0);
        v.segmented = (kind_in == 2'h2);
        v.progressive = kind_in[0];
        v.fractional = !kind_in[0];
        v.rate = (kind_in == 2'h2) ? 2'h2 : {1'b0, kind_in[0]};
    end
    // absent signal shows inverted figures, never the last good ones
    always_ff @(posedge clk_in) begin
        usable_out <= present_in;
        detect_out <= present_in ? v : ~v;
    end
endmodule
`default_nettype wire

// ### test/gtol_core_test.sv
// self-checking bench for the genlock offset and lock control block
`timescale 1ns/1ns
`default_nettype none
module gtol_core_test;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    gtol_pkg::gtol_fmt_t format_in = gtol_pkg::GTOL_FMT_NTSC;
    logic manual_mode_in = 1'b0;
    logic lock_now_in = 1'b0;
    logic present = 1'b0;
    logic [1:0] kind = 2'h0;
    logic ref_usable_in;
    gtol_pkg::gtol_detect_t detect_in;
    gtol_pkg::gtol_offset_t offset_req_in = '0;
    gtol_pkg::gtol_offset_t offset_out;
    logic offset_enable_out, locked_out, waiting_manual_out;
    logic external_reference_indicator_out, offset_clamped_out;
    gtol_pkg::gtol_cclk_t coarse_clk_out;
    gtol_pkg::gtol_hd_t hd_format_out;
    logic [11:0] expected_lines_out;
    int err_total = 0;
    int checked = 0;
    gtol_core dut (.core_clk_in, .rst_in, .format_in, .manual_mode_in, .lock_now_in,
        .ref_usable_in, .detect_in, .offset_req_in, .offset_out, .offset_enable_out,
        .coarse_clk_out, .hd_format_out, .expected_lines_out, .locked_out,
        .waiting_manual_out, .external_reference_indicator_out, .offset_clamped_out);
    gtol_ref_source src (.clk_in(core_clk_in), .present_in(present), .kind_in(kind),
        .usable_out(ref_usable_in), .detect_out(detect_in));
    // 250 MHz clock
    initial forever #2 core_clk_in = ~core_clk_in;
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    // lets the source stage and the output register land
    task automatic settle();
        repeat (3) @(posedge core_clk_in);
        #1;
    endtask
    task automatic t_formats();
        @(posedge core_clk_in);
        format_in <= gtol_pkg::GTOL_FMT_PAL;
        settle();
        chk(expected_lines_out, 12'h271);
        chk(coarse_clk_out, gtol_pkg::GTOL_CLK_54M);
        @(posedge core_clk_in);
        format_in <= gtol_pkg::GTOL_FMT_CW;
        offset_req_in <= {12'h005, 13'h0010, 8'h00};
        settle();
        chk(expected_lines_out, 12'h000);
        chk(offset_enable_out, 1'b1);
        @(posedge core_clk_in);
        format_in <= gtol_pkg::GTOL_FMT_PPS;
        settle();
        chk(offset_enable_out, 1'b0);
        chk(offset_out, 33'h0);
        @(posedge core_clk_in);
        format_in <= gtol_pkg::GTOL_FMT_NTSC;
        offset_req_in <= {12'hFFB, 13'h1FF0, 8'hFD};
        settle();
        chk(expected_lines_out, 12'h20D);
        chk(offset_out, {12'hFFB, 13'h1FF0, 8'hFD});
    endtask
    task automatic t_clamp();
        @(posedge core_clk_in);
        offset_req_in <= {12'h258, 13'h0000, 8'h78};
        settle();
        chk({offset_out.vert, offset_out.fine}, {12'h20D, 8'h64});
        chk(offset_clamped_out, 1'b1);
        @(posedge core_clk_in);
        offset_req_in <= {12'hDF3, 13'h0000, 8'h9C};
        settle();
        chk({offset_out.vert, offset_out.fine}, {12'hDF3, 8'h9C});
        chk(offset_clamped_out, 1'b0);
        @(posedge core_clk_in);
        format_in <= gtol_pkg::GTOL_FMT_PAL;
        offset_req_in <= {12'h4E2, 13'h0000, 8'h00};
        settle();
        chk(offset_out.vert, 12'h4E2);
        @(posedge core_clk_in);
        offset_req_in <= {12'h4E3, 13'h0000, 8'h00};
        settle();
        chk(offset_out.vert, 12'h4E2);
    endtask
    task automatic t_tri();
        @(posedge core_clk_in);
        format_in <= gtol_pkg::GTOL_FMT_TRI;
        present <= 1'b1;
        offset_req_in <= {12'h000, 13'h0FA0, 8'h50};
        settle();
        chk(hd_format_out, gtol_pkg::GTOL_HD_1080_5994I);
        chk(coarse_clk_out, gtol_pkg::GTOL_CLK_74M18);
        chk(expected_lines_out, 12'h465);
        chk(offset_out.fine, 8'h46);
        chk(offset_out.coarse, gtol_pkg::CLIM_1080_60);
        @(posedge core_clk_in);
        kind <= 2'h1;
        settle();
        chk(hd_format_out, gtol_pkg::GTOL_HD_720_50P);
        chk(coarse_clk_out, gtol_pkg::GTOL_CLK_74M25);
        chk(offset_out.coarse, gtol_pkg::CLIM_720_50);
        @(posedge core_clk_in);
        kind <= 2'h2;
        settle();
        chk(hd_format_out, gtol_pkg::GTOL_HD_1080_2398SF);
        chk(coarse_clk_out, gtol_pkg::GTOL_CLK_74M18);
        chk(offset_out.coarse, gtol_pkg::CLIM_1080_24);
        @(posedge core_clk_in);
        kind <= 2'h3;
        offset_req_in <= {12'hDA8, 13'h1060, 8'hB0};
        settle();
        chk(hd_format_out, gtol_pkg::GTOL_HD_1080_25P);
        chk(offset_out, {12'hDCE, 13'h15B0, 8'hBA});
    endtask
    task automatic t_lock();
        chk({locked_out, external_reference_indicator_out}, 2'b10);
        @(posedge core_clk_in);
        present <= 1'b0;
        settle();
        chk(locked_out, 1'b0);
        @(posedge core_clk_in);
        present <= 1'b1;
        settle();
        chk(locked_out, 1'b1);
        @(posedge core_clk_in);
        manual_mode_in <= 1'b1;
        present <= 1'b0;
        settle();
        chk({waiting_manual_out, external_reference_indicator_out}, 2'b11);
        @(posedge core_clk_in);
        present <= 1'b1;
        settle();
        chk({locked_out, waiting_manual_out}, 2'b01);
        @(posedge core_clk_in);
        lock_now_in <= 1'b1;
        settle();
        chk({locked_out, waiting_manual_out}, 2'b10);
        @(posedge core_clk_in);
        lock_now_in <= 1'b0;
    endtask
    // mid-run reset: status cleared, then first lock is automatic even in manual mode
    task automatic t_reset();
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        #1;
        chk({locked_out, waiting_manual_out, external_reference_indicator_out,
            offset_enable_out}, 4'h2);
        chk(hd_format_out, gtol_pkg::GTOL_HD_NONE);
        @(posedge core_clk_in);
        rst_in <= 1'b0;
        settle();
        chk({locked_out, waiting_manual_out, external_reference_indicator_out}, 3'h4);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // main sequence after 6 cycles of reset
    initial begin
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        t_formats();
        t_clamp();
        t_tri();
        t_lock();
        t_reset();
        stop_test();
    end
    // watchdog well beyond the expected run
    initial begin
        #20000;
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
